// ===== spiswp_link_model.sv
// Far-side serial master: one mode-0 frame of 8 bits per rise of go_in.
// Assumes the block samples the link pins with its own clock.
`default_nettype none
module spiswp_link_model #(
  parameter logic [7:0] TX_BYTE = 8'h3C
)
(
  input wire logic go_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic ss_n_out,
  output logic sdi_out,
  output logic [7:0] frames_out,
  output logic [7:0] got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  initial
  begin
    // Slave select idles high so the first frame gives a real falling edge
    {sck_out, ss_n_out, sdi_out, busy, frames_out} = 12'h400;
    got_out = 8'h00;
  end
  // Data line is unowned between frames, so keep it moving
  always #20 if (!busy) sdi_out = ~sdi_out;
  always @(posedge go_in)
  begin
    busy = 1'b1;
    ss_n_out = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--)
    begin
      sdi_out = TX_BYTE[i];
      #80 sck_out = 1'b1;
      got_out = {got_out[6:0], sdo_in};
      #80 sck_out = 1'b0;
    end
    #160 ss_n_out = 1'b1;
    busy = 1'b0;
    frames_out = frames_out + 8'h01;
  end
endmodule
`default_nettype wire

// ===== spiswp_pkg.sv
// Package of the serial status and write-protect block: register map,
// field positions, reset values and shared types.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
`default_nettype none
package spiswp_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_RXD = 8'h08;
  localparam logic [7:0] OFS_TXD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_IMR = 8'h14;
  localparam logic [7:0] OFS_CSEL = 8'h30;
  localparam logic [7:0] OFS_TCNT = 8'h40;
  localparam logic [7:0] OFS_TNCNT = 8'h44;
  localparam logic [7:0] OFS_WPMR = 8'hE4;
  localparam logic [7:0] OFS_WPSR = 8'hE8;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_EN = 0;
  localparam int BIT_DIS = 1;
  localparam int BIT_SLAVE = 0;
  localparam int BIT_PROT = 0;
  localparam int BIT_PROTECT_VIOLATION_FLAG = 0;
  localparam int LSB_WPSRC = 8;
  localparam int BIT_UNDER = 10;
  localparam int BIT_TX_DMA_BUFFER_EMPTY = 7;
  localparam int BIT_SSRISE = 8;
  localparam int BIT_TX_ALL_EMPTY_FLAG = 9;
  localparam int BIT_ENSTAT = 16;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam int CLK_MHZ = 50;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {SH_IDLE, SH_SHIFT, SH_DELAY} spiswp_shst_t;

  typedef struct packed {
    logic enable_status_bit;
    logic slave_underrun_flag;
    logic tx_all_empty_flag;
    logic slave_select_rise_flag;
    logic tx_dma_buffer_empty;
  } spiswp_stat_t;
endpackage
`default_nettype wire

// ===== spiswp_top.sv
// Serial controller status flags, transfer engine and register
// write protection behind an AXI4-Lite slave.
// Assumes link pins are asynchronous to sys_clk_in and are synchronised here.
`default_nettype none
module spiswp_top
  import spiswp_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sck_in,
  input wire logic slave_select_pin_n_in,
  input wire logic sdi_in,
  output logic sck_out,
  output logic sdo_out,
  output logic irq_out
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic upd(input logic flag, input logic set, input logic clr);
    upd = set | (flag & ~clr);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sck_sync_ff, ss_sync_ff, sdi_sync_ff;
  logic sck_ff, ss_n_ff, sdi_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sck_sync_ff <= 3'h0;
      ss_sync_ff <= 3'h7;
      sdi_sync_ff <= 3'h0;
      sck_ff <= 1'b0;
      ss_n_ff <= 1'b1;
      sdi_ff <= 1'b0;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[1:0], sck_in};
      ss_sync_ff <= {ss_sync_ff[1:0], slave_select_pin_n_in};
      sdi_sync_ff <= {sdi_sync_ff[1:0], sdi_in};
      if (sck_sync_ff[1] == sck_sync_ff[2])
        sck_ff <= sck_sync_ff[2];
      if (ss_sync_ff[1] == ss_sync_ff[2])
        ss_n_ff <= ss_sync_ff[2];
      if (sdi_sync_ff[1] == sdi_sync_ff[2])
        sdi_ff <= sdi_sync_ff[2];
    end
  end
  // Stage 1 feeds stage 2 only; edges come from agreeing later stages
  wire sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) & sck_sync_ff[2] & ~sck_ff;
  wire ss_rise = (ss_sync_ff[1] == ss_sync_ff[2]) & ss_sync_ff[2] & ~ss_n_ff;
  wire ss_fall = (ss_sync_ff[1] == ss_sync_ff[2]) & ~ss_sync_ff[2] & ss_n_ff;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_have_ff, w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid_out;
  wire rd_go = s_axi_arvalid_in & s_axi_arready_out;
  wire [7:0] wa = awaddr_ff;
  wire [7:0] ra = s_axi_araddr_in;
  wire full_word = (wstrb_ff == 4'hF);
  wire wa_known = (wa == OFS_CTRL) | (wa == OFS_MODE) | (wa == OFS_TXD) | (wa == OFS_IMR)
    | (wa == OFS_CSEL) | (wa == OFS_TCNT) | (wa == OFS_TNCNT) | (wa == OFS_WPMR);
  wire wa_prot = (wa == OFS_MODE) | (wa == OFS_CSEL);
  logic prot_en_ff;
  wire wr_block = wr_go & wa_prot & prot_en_ff;
  wire wr_ok = wr_go & wa_known & full_word & ~wr_block;
  wire wr_ctrl = wr_ok & (wa == OFS_CTRL);
  wire wr_mode = wr_ok & (wa == OFS_MODE);
  wire wr_txd = wr_ok & (wa == OFS_TXD);
  wire wr_imr = wr_ok & (wa == OFS_IMR);
  wire wr_csel = wr_ok & (wa == OFS_CSEL);
  wire wr_tcnt = wr_ok & (wa == OFS_TCNT);
  wire wr_tncnt = wr_ok & (wa == OFS_TNCNT);
  wire wr_wpmr = wr_ok & (wa == OFS_WPMR);
  wire rd_stat = rd_go & (ra == OFS_STAT);
  wire rd_wpsr = rd_go & (ra == OFS_WPSR);

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      s_axi_arready_out <= 1'b0;
    end
    else
    begin
      // Each channel taken once; ready lowers until the response is accepted
      s_axi_awready_out <= ~aw_have_ff & ~aw_take & ~s_axi_bvalid_out;
      s_axi_wready_out <= ~w_have_ff & ~w_take & ~s_axi_bvalid_out;
      if (aw_take)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_in;
      end
      if (w_take)
      begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      if (wr_go)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (wa_known & full_word) ? RESP_OKAY : RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
      else if (s_axi_bvalid_out & s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      s_axi_arready_out <= ~rd_go & ~s_axi_rvalid_out & ~s_axi_arready_out;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic enable_ff, slave_mode_ff;
  logic [7:0] delay_ff, txd_ff, rxd_ff;
  logic [15:0] tcnt_ff, tncnt_ff;
  logic [4:0] imr_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      enable_ff <= 1'b0;
      slave_mode_ff <= 1'b0;
      delay_ff <= RST_DELAY;
      tcnt_ff <= RST_CNT;
      tncnt_ff <= RST_CNT;
      imr_ff <= 5'h00;
      prot_en_ff <= 1'b0;
    end
    else
    begin
      // Disable wins over enable when both are written together
      if (wr_ctrl)
        enable_ff <= wdata_ff[BIT_DIS] ? 1'b0 : (wdata_ff[BIT_EN] | enable_ff);
      if (wr_mode)
        slave_mode_ff <= wdata_ff[BIT_SLAVE];
      if (wr_csel)
        delay_ff <= wdata_ff[7:0];
      if (wr_tcnt)
        tcnt_ff <= wdata_ff[15:0];
      if (wr_tncnt)
        tncnt_ff <= wdata_ff[15:0];
      if (wr_imr)
        imr_ff <= wdata_ff[4:0];
      if (wr_wpmr)
        prot_en_ff <= wdata_ff[BIT_PROT];
    end
  end

  // ---------------------------------------------------------------
  // Write protection status
  // ---------------------------------------------------------------
  logic protect_violation_flag_ff;
  logic [7:0] wpsrc_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      protect_violation_flag_ff <= 1'b0;
      wpsrc_ff <= 8'h00;
    end
    else
    begin
      protect_violation_flag_ff <= upd(protect_violation_flag_ff, wr_block, rd_wpsr);
      if (wr_block)
        wpsrc_ff <= wa;
    end
  end

  // ---------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------
  spiswp_shst_t st_ff;
  logic txd_full_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [7:0] dly_ff;
  logic [$clog2(SCK_HALF + 1)-1:0] div_ff;
  logic under_ff, ssr_ff, dma_empty_ff, tx_all_empty_flag_ff;
  wire master_tick = ~slave_mode_ff & (div_ff == '0) & sck_out;
  wire sh_tick = slave_mode_ff ? (sck_rise & ~ss_n_ff) : master_tick;
  wire start_master = ~slave_mode_ff & enable_ff & txd_full_ff;
  wire start_slave = slave_mode_ff & enable_ff & ss_fall;
  wire starting = (st_ff == SH_IDLE) & (start_master | start_slave);
  wire under_ev = (st_ff == SH_IDLE) & start_slave & ~txd_full_ff;
  wire last_bit = (st_ff == SH_SHIFT) & sh_tick & (bit_ff == 3'h7);
  wire slave_abort = (st_ff == SH_SHIFT) & slave_mode_ff & ss_rise;
  wire shift_end = last_bit | slave_abort;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_ff <= SH_IDLE;
      txd_ff <= 8'h00;
      txd_full_ff <= 1'b0;
      sh_ff <= 8'h00;
      rxd_ff <= 8'h00;
      bit_ff <= 3'h0;
      dly_ff <= 8'h00;
      div_ff <= '0;
      sck_out <= 1'b0;
      sdo_out <= 1'b0;
    end
    else
    begin
      if (wr_txd)
      begin
        txd_ff <= wdata_ff[7:0];
        txd_full_ff <= 1'b1;
      end
      else if (starting)
        txd_full_ff <= 1'b0;
      if ((st_ff == SH_SHIFT) & ~slave_mode_ff)
      begin
        div_ff <= (div_ff == '0) ? ($bits(div_ff))'(SCK_HALF - 1) : div_ff - 1'b1;
        if (div_ff == '0)
          sck_out <= ~sck_out;
      end
      else
      begin
        div_ff <= ($bits(div_ff))'(SCK_HALF - 1);
        sck_out <= 1'b0;
      end
      case (st_ff)
        SH_IDLE:
        begin
          if (starting)
          begin
            // Underrun shifts out zeros
            sh_ff <= txd_full_ff ? txd_ff : 8'h00;
            bit_ff <= 3'h0;
            st_ff <= SH_SHIFT;
          end
        end
        SH_SHIFT:
        begin
          if (sh_tick)
          begin
            sh_ff <= {sh_ff[6:0], sdi_ff};
            bit_ff <= bit_ff + 3'h1;
            if (last_bit)
              rxd_ff <= {sh_ff[6:0], sdi_ff};
          end
          if (shift_end)
          begin
            dly_ff <= delay_ff;
            st_ff <= (delay_ff != 8'h00) ? SH_DELAY : SH_IDLE;
          end
        end
        SH_DELAY:
        begin
          dly_ff <= dly_ff - 8'h01;
          if (dly_ff == 8'h01)
            st_ff <= SH_IDLE;
        end
        default:
          st_ff <= SH_IDLE;
      endcase
      sdo_out <= (st_ff == SH_SHIFT) ? sh_ff[7] : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status flags and interrupt
  // ---------------------------------------------------------------
  wire tx_all_empty_flag_next = ~txd_full_ff & (st_ff == SH_IDLE) & ~starting;
  spiswp_stat_t stat;
  assign stat = '{enable_status_bit: enable_ff, slave_underrun_flag: under_ff,
                  tx_all_empty_flag: tx_all_empty_flag_ff, slave_select_rise_flag: ssr_ff,
                  tx_dma_buffer_empty: dma_empty_ff};
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      under_ff <= 1'b0;
      ssr_ff <= 1'b0;
      dma_empty_ff <= 1'b1;
      tx_all_empty_flag_ff <= 1'b1;
      irq_out <= 1'b0;
    end
    else
    begin
      under_ff <= upd(under_ff, under_ev, rd_stat);
      ssr_ff <= upd(ssr_ff, ss_rise, rd_stat);
      // A counter write always clears; empty shows next cycle only if both counters are zero
      dma_empty_ff <= ~(wr_tcnt | wr_tncnt) & (tcnt_ff == 16'h0000) & (tncnt_ff == 16'h0000);
      tx_all_empty_flag_ff <= ~wr_txd & tx_all_empty_flag_next;
      irq_out <= |(stat & imr_ff);
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (ra)
      OFS_CTRL: rmux = 32'h0000_0000;
      OFS_MODE: rmux[BIT_SLAVE] = slave_mode_ff;
      OFS_RXD: rmux[7:0] = rxd_ff;
      OFS_TXD: rmux = 32'h0000_0000;
      OFS_STAT:
      begin
        rmux[BIT_ENSTAT] = stat.enable_status_bit;
        rmux[BIT_UNDER] = stat.slave_underrun_flag;
        rmux[BIT_TX_ALL_EMPTY_FLAG] = stat.tx_all_empty_flag;
        rmux[BIT_SSRISE] = stat.slave_select_rise_flag;
        rmux[BIT_TX_DMA_BUFFER_EMPTY] = stat.tx_dma_buffer_empty;
      end
      OFS_IMR: rmux[4:0] = imr_ff;
      OFS_CSEL: rmux[7:0] = delay_ff;
      OFS_TCNT: rmux[15:0] = tcnt_ff;
      OFS_TNCNT: rmux[15:0] = tncnt_ff;
      OFS_WPMR: rmux[BIT_PROT] = prot_en_ff;
      OFS_WPSR:
      begin
        rmux[BIT_PROTECT_VIOLATION_FLAG] = protect_violation_flag_ff;
        rmux[LSB_WPSRC +: 8] = wpsrc_ff;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end
  wire ra_known = (ra == OFS_CTRL) | (ra == OFS_MODE) | (ra == OFS_RXD) | (ra == OFS_TXD)
    | (ra == OFS_STAT) | (ra == OFS_IMR) | (ra == OFS_CSEL) | (ra == OFS_TCNT)
    | (ra == OFS_TNCNT) | (ra == OFS_WPMR) | (ra == OFS_WPSR);

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rmux;
      s_axi_rresp_out <= ra_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid_out & s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== spiswp_top_assertions.sv
// Checker of bus answers, refusals, enable status and interrupt masking.
// Assumes the master offers write address and write data together.
`default_nettype none
module spiswp_top_assertions
  import spiswp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic irq_out
);
  // ---------------------------------------------------------------
  // Shadow of software intent
  // ---------------------------------------------------------------
  logic [7:0] ra_ff;
  logic en_ff;
  logic prot_ff;
  logic [4:0] imr_ff;
  logic [1:0] quiet_ff;
  wire wr_t = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  wire rd_t = s_axi_arvalid_in && s_axi_arready_out;
  wire full_t = wr_t && s_axi_wstrb_in == 4'hF;
  wire [7:0] wa = s_axi_awaddr_in;
  wire [31:0] wd = s_axi_wdata_in;
  // Holes above 0x7F up to 0xDF are unmapped
  wire bad_wa = wa[7] && wa[7:5] != 3'h7;
  wire bad_ra = s_axi_araddr_in[7] && s_axi_araddr_in[7:5] != 3'h7;
  wire prot_t = full_t && prot_ff && (wa == OFS_MODE || wa == OFS_CSEL);
  wire nxt_en = (full_t && wa == OFS_CTRL) ? ~wd[BIT_DIS] & (wd[BIT_EN] | en_ff) : en_ff;
  wire nxt_prot = (full_t && wa == OFS_WPMR) ? wd[BIT_PROT] : prot_ff;
  wire [4:0] nxt_imr = (full_t && wa == OFS_IMR) ? wd[4:0] : imr_ff;
  // Mask and irq are both registered, so give them three edges
  wire [1:0] nxt_quiet = (imr_ff != 5'h00) ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      {ra_ff, en_ff, prot_ff, imr_ff, quiet_ff} <= 17'h00000;
    else
      {ra_ff, en_ff, prot_ff, imr_ff, quiet_ff} <= {rd_t ? s_axi_araddr_in : ra_ff, nxt_en, nxt_prot, nxt_imr, nxt_quiet};
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_bad_wr;
    wr_t && (s_axi_wstrb_in != 4'hF || bad_wa);
  endsequence
  sequence s_err_answer;
    s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR;
  endsequence
  // Both channels are latched first, so the answer comes two edges after the take
  write_answer_a: assert property (wr_t |-> ##2 s_axi_bvalid_out) else $error("write not answered");
  bad_write_a: assert property (s_bad_wr |-> ##2 s_err_answer) else $error("bad write not refused");
  read_answer_a: assert property (rd_t |=> s_axi_rvalid_out) else $error("read not answered");
  bad_read_a: assert property (rd_t && bad_ra |=> s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR)
    else $error("bad read not refused");
  read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while pending");
  protect_okay_a: assert property (prot_t |-> ##2 s_axi_bvalid_out && s_axi_bresp_out == RESP_OKAY)
    else $error("blocked write answer wrong");
  enable_status_a: assert property ($rose(s_axi_rvalid_out) && ra_ff == OFS_STAT |->
    s_axi_rdata_out[BIT_ENSTAT] == en_ff && s_axi_rdata_out[31:17] == 15'h0000) else $error("enable status wrong");
  irq_masked_a: assert property (quiet_ff == 2'h3 |-> !irq_out) else $error("irq while fully masked");
endmodule
bind spiswp_top spiswp_top_assertions u_chk (.sys_clk_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rvalid_out, .irq_out);
`default_nettype wire

// ===== tb_spi_status_and_write_protect.sv
// Register-level bench of the status and write-protect block.
// Assumes the link model stands in for the far-side master.
`default_nettype none
module tb_spi_status_and_write_protect;
  import spiswp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  localparam logic [31:0] DLY = 32'h40;
  localparam logic [7:0] DMA_A [4] = '{OFS_TCNT, OFS_TNCNT, OFS_TCNT, OFS_TNCNT};
  localparam logic [31:0] DMA_D [4] = '{32'h5, 32'h3, 32'h0, 32'h0};
  localparam logic [31:0] DMA_E [4] = '{32'h0, 32'h0, 32'h0, 32'h80};
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00;
  logic [7:0] s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'b0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic go = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic sck_out, sdo_out, irq_out;
  wire logic sck_in, slave_select_pin_n_in, sdi_in;
  wire logic [7:0] frames, got;
  int sck_edges = 0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc++;
  always @(posedge sck_out) sck_edges++;
  spiswp_top #(.SCK_HALF(HALF)) u_dut (.sys_clk_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .sck_in, .slave_select_pin_n_in,
    .sdi_in, .sck_out, .sdo_out, .irq_out);
  spiswp_link_model u_far (.go_in(go), .sdo_in(sdo_out), .sck_out(sck_in), .ss_n_out(slave_select_pin_n_in),
    .sdi_out(sdi_in), .frames_out(frames), .got_out(got));
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d of %0d checks", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    samples_checked++;
    if ((g & m) !== (e & m))
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task automatic chkr(input string n, input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic lost;
    fail_count++;
    close_out();
  endtask
  // Handshakes judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit ta, tw, tk;
    int n;
    @(posedge sys_clk_in);
    {s_axi_awaddr_in, s_axi_wdata_in, s_axi_wstrb_in} <= {a, d, s};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    for (n = 0; n < 64 && !tk; n++)
    begin
      @(negedge sys_clk_in);
      {ta, tw, tk, r} = {s_axi_awvalid_in & s_axi_awready_out, s_axi_wvalid_in & s_axi_wready_out,
        s_axi_bvalid_out, s_axi_bresp_out};
      @(posedge sys_clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end
    s_axi_bready_in <= 1'b0;
    if (!tk) lost();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta, tk;
    int n;
    @(posedge sys_clk_in);
    {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'h3};
    for (n = 0; n < 64 && !tk; n++)
    begin
      @(negedge sys_clk_in);
      {ta, tk, d, r} = {s_axi_arvalid_in & s_axi_arready_out, s_axi_rvalid_out, s_axi_rdata_out, s_axi_rresp_out};
      @(posedge sys_clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
    end
    s_axi_rready_in <= 1'b0;
    if (!tk) lost();
  endtask
  task automatic frame;
    logic [7:0] f0;
    int n;
    f0 = frames;
    @(posedge sys_clk_in);
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (n = 0; n < 200 && frames === f0; n++) @(posedge sys_clk_in);
    if (n == 200) lost();
    // Let the transfer delay run out so the next frame start is not missed
    repeat (80) @(negedge sys_clk_in);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a;
    int t0;
    repeat (10) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd(OFS_STAT, d, r);
    chk("status reset", 32'h280, d, 32'hFFFFFFFF);
    wr(8'h80, 32'h1, 4'hF, r);
    chkr("unmapped write", RESP_SLVERR, r);
    rd(8'h80, d, r);
    chkr("unmapped read", RESP_SLVERR, r);
    wr(OFS_IMR, 32'h1F, 4'h3, r);
    chkr("partial strobe", RESP_SLVERR, r);
    for (int n = 0; n < 4; n++)
    begin
      wr(DMA_A[n], DMA_D[n], 4'hF, r);
      rd(OFS_STAT, d, r);
      chk("dma empty", DMA_E[n], d, 32'h80);
    end
    wr(OFS_CTRL, 32'h1, 4'hF, r);
    wr(OFS_CSEL, DLY, 4'hF, r);
    rd(OFS_STAT, d, r);
    chk("enabled", 32'h10000, d, 32'h10000);
    wr(OFS_TXD, 32'hA5, 4'hF, r);
    t0 = cyc;
    rd(OFS_STAT, d, r);
    chk("tx busy", 32'h0, d, 32'h200);
    for (int n = 0; n < 100 && d[BIT_TX_ALL_EMPTY_FLAG] !== 1'b1; n++) rd(OFS_STAT, d, r);
    chk("tx empty late", 32'h1, {31'h0, (cyc - t0) >= 16 * HALF + DLY}, 32'h1);
    chk("master no underrun", 32'h200, d, 32'h600);
    chk("sck edges", 32'h8, sck_edges, 32'hFF);
    wr(OFS_MODE, 32'h1, 4'hF, r);
    wr(OFS_IMR, 32'h0, 4'hF, r);
    frame();
    chk("irq masked", 32'h0, {31'h0, irq_out}, 32'h1);
    rd(OFS_STAT, d, r);
    chk("rise and underrun", 32'h500, d, 32'h500);
    rd(OFS_STAT, d, r);
    chk("cleared on read", 32'h0, d, 32'h500);
    rd(OFS_RXD, d, r);
    chk("rx byte", 32'h3C, d, 32'hFF);
    wr(OFS_IMR, 32'h2, 4'hF, r);
    wr(OFS_TXD, 32'h5A, 4'hF, r);
    frame();
    chk("irq raised", 32'h1, {31'h0, irq_out}, 32'h1);
    chk("slave out", 32'h5A, {24'h0, got}, 32'hFF);
    rd(OFS_STAT, d, r);
    chk("loaded no underrun", 32'h100, d, 32'h500);
    repeat (4) @(negedge sys_clk_in);
    chk("irq cleared", 32'h0, {31'h0, irq_out}, 32'h1);
    wr(OFS_WPMR, 32'h1, 4'hF, r);
    for (int n = 0; n < 2; n++)
    begin
      a = n ? OFS_CSEL : OFS_MODE;
      wr(a, 32'h0, 4'hF, r);
      chkr("blocked answer", RESP_OKAY, r);
      rd(OFS_WPSR, d, r);
      chk("violation", {16'h0, a, 8'h01}, d, 32'hFF01);
      rd(OFS_WPSR, d, r);
      chk("violation cleared", 32'h0, d, 32'h1);
    end
    rd(OFS_MODE, d, r);
    chk("mode kept", 32'h1, d, 32'h1);
    rd(OFS_CSEL, d, r);
    chk("csel kept", DLY, d, 32'hFF);
    wr(OFS_IMR, 32'h0, 4'hF, r);
    rd(OFS_IMR, d, r);
    chk("imr open", 32'h0, d, 32'h1F);
    wr(OFS_WPMR, 32'h0, 4'hF, r);
    wr(OFS_MODE, 32'h0, 4'hF, r);
    rd(OFS_MODE, d, r);
    chk("mode open", 32'h0, d, 32'h1);
    wr(OFS_CTRL, 32'h3, 4'hF, r);
    rd(OFS_STAT, d, r);
    chk("disabled", 32'h0, d, 32'h10000);
    close_out();
  end
endmodule
`default_nettype wire
